// file: logic/asr_status_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// - The strap pin is caught after reset into bit 3 of register 0x00 and picks base 0x6c over 0x4c.
// - Bit 0 of register 0x01 goes high when a new sample replaces one that the host never read.
// - Bit 1 of register 0x01 shows whether the internal clocks are powered down.
// - Bit 5 of register 0x01 shows that the one-time memory supply is on and the memory powered.
// - Bit 6 of register 0x01 shows that the activity-watch mode is active.
// - Bit 7 of register 0x01 shows that an activity event was seen; continuous wake follows only when bit 6 is also set.
// - Each axis is a low and high byte at 0x02..0x07 in X, Y, Z order, sign-extended.
// - No sample reaches the axis registers while both interface select bits are zero.
// - With the FIFO enabled its head is shown in the six axis registers at 12-bit resolution.
// - The FIFO advances only after a complete in-order read of 0x02 through 0x07.
// - Readable contents stay frozen from a recognised START until the matching STOP.
// - An activity event in activity-watch mode requests continuous wake on its own.

module asr_fifo #(
    parameter int W     = 36,
    parameter int DEPTH = 16
) (
    input  wire logic         sys_clk_in,
    input  wire logic         rst_n_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    input  wire logic [W-1:0] in_data_in,
    output logic              out_valid_out,
    input  wire logic         out_ready_in,
    output logic [W-1:0]      out_data_out
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0]             wr;
        logic [AW:0]             rd;
    } asr_fifo_t;

    asr_fifo_t s_r;
    asr_fifo_t s_nxt;
    logic      full;
    logic      empty;

    assign empty         = (s_r.wr == s_r.rd);
    assign full          = (s_r.wr[AW-1:0] == s_r.rd[AW-1:0]) && (s_r.wr[AW] != s_r.rd[AW]);
    assign in_ready_out  = !full;
    assign out_valid_out = !empty;
    assign out_data_out  = s_r.mem[s_r.rd[AW-1:0]];

    always_comb
    begin
        s_nxt = s_r;
        if (in_valid_in && !full)
        begin
            s_nxt.mem[s_r.wr[AW-1:0]] = in_data_in;
            s_nxt.wr = s_r.wr + 1'b1;
        end
        if (out_ready_in && !empty)
        begin
            s_nxt.rd = s_r.rd + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end
endmodule

module asr_status_regs #(
    parameter int SAMPLE_W = 14
) (
    input  wire logic                sys_clk_in,
    input  wire logic                rst_n_in,
    input  wire logic                address_strap_pin_in,
    output logic [6:0]               i2c_base_addr_out,
    input  wire logic                iface_i2c_en_in,
    input  wire logic                iface_spi_en_in,
    input  wire logic                fifo_en_in,
    input  wire logic                clock_powerdown_flag_in,
    input  wire logic                otp_powered_in,
    input  wire logic                sniff_active_in,
    input  wire logic                sniff_detect_in,
    output logic                     continuous_wake_mode_out,
    input  wire logic                sample_valid_in,
    output logic                     sample_ready_out,
    input  wire logic [SAMPLE_W-1:0] x_sample_in,
    input  wire logic [SAMPLE_W-1:0] y_sample_in,
    input  wire logic [SAMPLE_W-1:0] z_sample_in,
    input  wire logic                link_clk_in,
    input  wire logic                link_start_in,
    input  wire logic                link_stop_in,
    input  wire logic                link_addr_load_in,
    input  wire logic [7:0]          link_addr_in,
    input  wire logic                link_read_in,
    input  wire logic                link_write_in,
    output logic [7:0]               link_rdata_out,
    output logic                     link_rvalid_out,
    output logic                     link_busy_out
);
    localparam int FW = asr_pkg::ASR_AXES * asr_pkg::ASR_FIFO_RES;
    localparam int SW = asr_pkg::ASR_AXES * SAMPLE_W;

    typedef struct packed {
        logic                                           strap_s1;
        logic                                           strap_s2;
        logic [1:0]                                     strap_cnt;
        logic                                           strap_done;
        logic                                           addr_sel;
        logic                                           frz_s1;
        logic                                           frz_s2;
        logic                                           req_s1;
        logic                                           req_s2;
        logic                                           req_seen;
        logic                                           ack_tgl;
        logic [7:0]                                     rdata;
        logic [7:0]                                     cond;
        logic [asr_pkg::ASR_AXES-1:0][asr_pkg::ASR_OUT_W-1:0] axis;
        logic                                           unread;
        logic                                           ovr;
        logic                                           pend_v;
        logic [SW-1:0]                                  pend;
        logic [2:0]                                     seq;
        logic                                           pop;
        logic                                           continuous_wake_mode;
    } asr_sys_t;

    typedef struct packed {
        logic       freeze;
        logic [7:0] ptr;
        logic [7:0] rd_addr;
        logic       req_tgl;
        logic       ack_s1;
        logic       ack_s2;
        logic       ack_seen;
        logic [7:0] rdata;
        logic       rvalid;
        logic       busy;
    } asr_link_t;

    asr_sys_t  s_r;
    asr_sys_t  s_nxt;
    asr_link_t l_r;
    asr_link_t l_nxt;
    logic [1:0] sys_rst_r;
    logic [1:0] link_rst_r;
    logic       sys_rst_n;
    logic       link_rst_n;
    logic       iface_ok;
    logic       fifo_in_valid;
    logic       fifo_in_ready;
    logic [FW-1:0] fifo_in_data;
    logic       fifo_out_valid;
    logic [FW-1:0] fifo_out_data;

    function automatic logic [15:0] sext_fifo(input logic [asr_pkg::ASR_FIFO_RES-1:0] v);
        sext_fifo = {{(asr_pkg::ASR_OUT_W - asr_pkg::ASR_FIFO_RES){v[asr_pkg::ASR_FIFO_RES-1]}}, v};
    endfunction

    function automatic logic [15:0] sext_direct(input logic [SAMPLE_W-1:0] v);
        sext_direct = {{(asr_pkg::ASR_OUT_W - SAMPLE_W){v[SAMPLE_W-1]}}, v};
    endfunction

    // Reset release is synchronised separately in each clock domain.
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sys_rst_r <= 2'h0;
        end
        else
        begin
            sys_rst_r <= {sys_rst_r[0], 1'b1};
        end
    end

    always_ff @(posedge link_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            link_rst_r <= 2'h0;
        end
        else
        begin
            link_rst_r <= {link_rst_r[0], 1'b1};
        end
    end

    assign sys_rst_n  = sys_rst_r[1];
    assign link_rst_n = link_rst_r[1];

    // The FIFO stores the top 12 bits of each axis; lower bits are dropped.
    assign iface_ok         = iface_i2c_en_in || iface_spi_en_in;
    assign fifo_in_valid    = sample_valid_in && iface_ok && fifo_en_in;
    assign fifo_in_data     = {z_sample_in[SAMPLE_W-1 -: asr_pkg::ASR_FIFO_RES],
                               y_sample_in[SAMPLE_W-1 -: asr_pkg::ASR_FIFO_RES],
                               x_sample_in[SAMPLE_W-1 -: asr_pkg::ASR_FIFO_RES]};
    assign sample_ready_out = fifo_en_in ? fifo_in_ready : 1'b1;

    asr_fifo #(
        .W     (FW),
        .DEPTH (asr_pkg::ASR_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_in    (sys_clk_in),
        .rst_n_in      (sys_rst_n),
        .in_valid_in   (fifo_in_valid),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (fifo_in_data),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (s_r.pop),
        .out_data_out  (fifo_out_data)
    );

    function automatic logic [7:0] reg_byte(input asr_sys_t st, input logic [7:0] a);
        logic [7:0] b;
        b = 8'h00;
        case (a)
            asr_pkg::ASR_ADDR_SEL_OFF: b[asr_pkg::ASR_ADDR_SEL_BIT] = st.addr_sel;
            asr_pkg::ASR_COND_OFF:     b = st.cond;
            asr_pkg::ASR_X_LO_OFF:     b = st.axis[0][7:0];
            asr_pkg::ASR_X_HI_OFF:     b = st.axis[0][15:8];
            asr_pkg::ASR_Y_LO_OFF:     b = st.axis[1][7:0];
            asr_pkg::ASR_Y_HI_OFF:     b = st.axis[1][15:8];
            asr_pkg::ASR_Z_LO_OFF:     b = st.axis[2][7:0];
            asr_pkg::ASR_Z_HI_OFF:     b = st.axis[2][15:8];
            default:                   b = 8'h00;
        endcase
        reg_byte = b;
    endfunction

    always_comb
    begin
        logic       frozen;
        logic       rd_evt;
        logic [7:0] ra;
        logic       load_now;
        logic       ovr_set;
        logic       ovr_clr;
        frozen   = 1'b0;
        rd_evt   = 1'b0;
        ra       = l_r.rd_addr;
        load_now = 1'b0;
        ovr_set  = 1'b0;
        ovr_clr  = 1'b0;
        s_nxt    = s_r;

        s_nxt.strap_s1 = address_strap_pin_in;
        s_nxt.strap_s2 = s_r.strap_s1;
        if (!s_r.strap_done)
        begin
            s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
            if (s_r.strap_cnt == asr_pkg::ASR_STRAP_WAIT)
            begin
                s_nxt.addr_sel   = s_r.strap_s2;
                s_nxt.strap_done = 1'b1;
            end
        end

        s_nxt.frz_s1   = l_r.freeze;
        s_nxt.frz_s2   = s_r.frz_s1;
        s_nxt.req_s1   = l_r.req_tgl;
        s_nxt.req_s2   = s_r.req_s1;
        s_nxt.req_seen = s_r.req_s2;
        frozen         = s_r.frz_s2;
        rd_evt         = (s_r.req_s2 != s_r.req_seen);
        s_nxt.pop      = 1'b0;
        s_nxt.continuous_wake_mode    = sniff_active_in && sniff_detect_in;

        // The link holds rd_addr steady until the answer comes back.
        if (rd_evt)
        begin
            s_nxt.rdata   = reg_byte(s_r, ra);
            s_nxt.ack_tgl = !s_r.ack_tgl;
            if (ra == asr_pkg::ASR_COND_OFF)
            begin
                ovr_clr = 1'b1;
            end
            if (ra == asr_pkg::ASR_Z_HI_OFF)
            begin
                s_nxt.unread = 1'b0;
            end
            if (ra == asr_pkg::ASR_X_LO_OFF)
            begin
                s_nxt.seq = 3'h1;
            end
            else if (s_r.seq != 3'h0 && ra == asr_pkg::ASR_X_LO_OFF + {5'h00, s_r.seq})
            begin
                s_nxt.seq = s_r.seq + 3'h1;
                if (s_r.seq == asr_pkg::ASR_SEQ_LAST)
                begin
                    s_nxt.seq = 3'h0;
                    s_nxt.pop = fifo_en_in;
                end
            end
            else
            begin
                s_nxt.seq = 3'h0;
            end
        end

        // Direct samples wait in a one-deep holder while the registers are frozen.
        if (sample_valid_in && iface_ok && !fifo_en_in)
        begin
            if (s_r.pend_v && frozen)
            begin
                ovr_set = 1'b1;
            end
            s_nxt.pend_v = 1'b1;
            s_nxt.pend   = {z_sample_in, y_sample_in, x_sample_in};
        end

        if (!frozen)
        begin
            if (fifo_en_in)
            begin
                if (fifo_out_valid)
                begin
                    for (int i = 0; i < asr_pkg::ASR_AXES; i++)
                    begin
                        s_nxt.axis[i] = sext_fifo(
                            fifo_out_data[i*asr_pkg::ASR_FIFO_RES +: asr_pkg::ASR_FIFO_RES]);
                    end
                end
            end
            else if (s_nxt.pend_v)
            begin
                load_now = 1'b1;
                for (int i = 0; i < asr_pkg::ASR_AXES; i++)
                begin
                    s_nxt.axis[i] = sext_direct(s_nxt.pend[i*SAMPLE_W +: SAMPLE_W]);
                end
                s_nxt.pend_v = 1'b0;
            end
            s_nxt.cond = 8'h00;
            s_nxt.cond[asr_pkg::ASR_OVR_BIT]       = s_r.ovr;
            s_nxt.cond[asr_pkg::ASR_CLKPD_BIT]     = clock_powerdown_flag_in;
            s_nxt.cond[asr_pkg::ASR_OTP_BIT]       = otp_powered_in;
            s_nxt.cond[asr_pkg::ASR_SNIFF_EN_BIT]  = sniff_active_in;
            s_nxt.cond[asr_pkg::ASR_SNIFF_DET_BIT] = sniff_detect_in;
        end

        if (load_now)
        begin
            if (s_r.unread)
            begin
                ovr_set = 1'b1;
            end
            s_nxt.unread = 1'b1;
        end

        // A new overwrite in the cycle of a status read keeps the flag set.
        if (ovr_set)
        begin
            s_nxt.ovr = 1'b1;
        end
        else if (ovr_clr)
        begin
            s_nxt.ovr = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge sys_rst_n)
    begin
        if (!sys_rst_n)
        begin
            s_r          <= '0;
            s_r.addr_sel <= asr_pkg::ASR_ADDR_SEL_RESET[asr_pkg::ASR_ADDR_SEL_BIT];
            s_r.cond     <= asr_pkg::ASR_COND_RESET;
            s_r.axis     <= {asr_pkg::ASR_AXES{asr_pkg::ASR_SAMPLE_RESET}};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    always_comb
    begin
        l_nxt          = l_r;
        l_nxt.ack_s1   = s_r.ack_tgl;
        l_nxt.ack_s2   = l_r.ack_s1;
        l_nxt.ack_seen = l_r.ack_s2;
        l_nxt.rvalid   = 1'b0;

        if (link_stop_in)
        begin
            l_nxt.freeze = 1'b0;
        end
        if (link_start_in)
        begin
            l_nxt.freeze = 1'b1;
        end

        if (link_addr_load_in)
        begin
            l_nxt.ptr = link_addr_in;
        end
        if (link_read_in && !l_r.busy)
        begin
            l_nxt.rd_addr = l_nxt.ptr;
            l_nxt.ptr     = l_nxt.ptr + 8'h01;
            l_nxt.req_tgl = !l_r.req_tgl;
            l_nxt.busy    = 1'b1;
        end
        else if (link_write_in && !l_r.busy)
        begin
            l_nxt.ptr = l_nxt.ptr + 8'h01;
        end

        // The sys side holds rdata until the next request is seen.
        if (l_r.ack_s2 != l_r.ack_seen)
        begin
            l_nxt.rdata  = s_r.rdata;
            l_nxt.rvalid = 1'b1;
            l_nxt.busy   = 1'b0;
        end
    end

    always_ff @(posedge link_clk_in or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            l_r <= '0;
        end
        else
        begin
            l_r <= l_nxt;
        end
    end

    assign i2c_base_addr_out        = s_r.addr_sel ? asr_pkg::ASR_I2C_BASE_HIGH
                                                   : asr_pkg::ASR_I2C_BASE_LOW;
    assign continuous_wake_mode_out = s_r.continuous_wake_mode;
    assign link_rdata_out           = l_r.rdata;
    assign link_rvalid_out          = l_r.rvalid;
    assign link_busy_out            = l_r.busy;
endmodule

// file: shared/asr_pkg.sv
package asr_pkg;

    // Register offsets as seen by the serial front end.
    localparam logic [7:0] ASR_ADDR_SEL_OFF = 8'h00;
    localparam logic [7:0] ASR_COND_OFF     = 8'h01;
    localparam logic [7:0] ASR_X_LO_OFF     = 8'h02;
    localparam logic [7:0] ASR_X_HI_OFF     = 8'h03;
    localparam logic [7:0] ASR_Y_LO_OFF     = 8'h04;
    localparam logic [7:0] ASR_Y_HI_OFF     = 8'h05;
    localparam logic [7:0] ASR_Z_LO_OFF     = 8'h06;
    localparam logic [7:0] ASR_Z_HI_OFF     = 8'h07;

    // Field positions.
    localparam int ASR_ADDR_SEL_BIT  = 3;
    localparam int ASR_OVR_BIT       = 0;
    localparam int ASR_CLKPD_BIT     = 1;
    localparam int ASR_OTP_BIT       = 5;
    localparam int ASR_SNIFF_EN_BIT  = 6;
    localparam int ASR_SNIFF_DET_BIT = 7;

    // Reset values.
    localparam logic [7:0]  ASR_ADDR_SEL_RESET = 8'h00;
    localparam logic [7:0]  ASR_COND_RESET     = 8'h04;
    localparam logic [15:0] ASR_SAMPLE_RESET   = 16'h0000;

    // Serial target base addresses selected by the strap.
    localparam logic [6:0] ASR_I2C_BASE_LOW  = 7'h4c;
    localparam logic [6:0] ASR_I2C_BASE_HIGH = 7'h6c;

    // Sample layout and buffering.
    localparam int ASR_OUT_W      = 16;
    localparam int ASR_AXES       = 3;
    localparam int ASR_FIFO_RES   = 12;
    localparam int ASR_FIFO_DEPTH = 16;

    // Index of the last byte of a complete 0x02..0x07 burst, and the
    // cycle after reset release at which the strap is caught.
    localparam logic [2:0] ASR_SEQ_LAST   = 3'h5;
    localparam logic [1:0] ASR_STRAP_WAIT = 2'h2;

endpackage

// file: verif/asr_status_properties.sv
`timescale 1ns/1ps
module asr_status_properties (
    input wire logic       sys_clk_in,
    input wire logic       rst_n_in,
    input wire logic [6:0] i2c_base_addr_out,
    input wire logic       fifo_en_in,
    input wire logic       sniff_active_in,
    input wire logic       sniff_detect_in,
    input wire logic       continuous_wake_mode_out,
    input wire logic       sample_ready_out,
    input wire logic       link_clk_in,
    input wire logic       link_read_in,
    input wire logic [7:0] link_rdata_out,
    input wire logic       link_rvalid_out,
    input wire logic       link_busy_out
);
    chk_base_legal: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        i2c_base_addr_out == 7'h4c || i2c_base_addr_out == 7'h6c)
        else $error("base address is neither strap choice");
    chk_wake_request: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        sniff_active_in && sniff_detect_in |=> continuous_wake_mode_out)
        else $error("event in watch mode did not request wake");
    chk_wake_drop: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        !sniff_active_in |=> !continuous_wake_mode_out)
        else $error("wake requested outside watch mode");
    chk_ready_direct: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        !fifo_en_in |-> sample_ready_out)
        else $error("samples refused without the fifo");
    chk_read_answer: assert property (
        @(posedge link_clk_in) disable iff (!rst_n_in)
        link_read_in && !link_busy_out |=> link_busy_out ##[1:20] link_rvalid_out)
        else $error("read not answered in time");
    chk_rvalid_pulse: assert property (
        @(posedge link_clk_in) disable iff (!rst_n_in)
        link_rvalid_out |-> !link_busy_out ##1 !link_rvalid_out)
        else $error("answer strobe malformed");
    chk_rdata_hold: assert property (
        @(posedge link_clk_in) disable iff (!rst_n_in)
        $changed(link_rdata_out) |-> link_rvalid_out)
        else $error("read data moved without an answer");
    chk_busy_cause: assert property (
        @(posedge link_clk_in) disable iff (!rst_n_in)
        $rose(link_busy_out) |-> $past(link_read_in))
        else $error("busy without a read");
    cov_answer: cover property (@(posedge link_clk_in) link_rvalid_out);
    cov_wake: cover property (@(posedge sys_clk_in) continuous_wake_mode_out);
    cov_full: cover property (@(posedge sys_clk_in) !sample_ready_out);
endmodule

// file: verif/asr_host_model.sv
`timescale 1ns/1ps
module asr_host_model (
    input  wire logic link_clk_in,
    input  wire logic busy_in,
    input  wire logic rvalid_in,
    output logic      start_out,
    output logic      stop_out,
    output logic      load_out,
    output logic [7:0] addr_out,
    output logic      read_out,
    output logic      write_out
);
    initial
    begin
        {start_out, stop_out, load_out, read_out, write_out} = 5'h00;
        addr_out = 8'h00;
    end

    task automatic mark(input bit stp);
        @(posedge link_clk_in);
        start_out <= !stp;
        stop_out <= stp;
        @(posedge link_clk_in);
        start_out <= 1'b0;
        stop_out <= 1'b0;
    endtask

    // An address that is not loaded is scrambled so nothing can lean on a stale value.
    task automatic xfer(input logic [7:0] a, input bit ld, input bit wr, output bit ok);
        @(posedge link_clk_in);
        load_out <= ld;
        addr_out <= ld ? a : ~addr_out;
        read_out <= !wr;
        write_out <= wr;
        @(posedge link_clk_in);
        load_out <= 1'b0;
        read_out <= 1'b0;
        write_out <= 1'b0;
        addr_out <= ~addr_out;
        ok = wr;
        for (int n = 0; n < 20 && !ok; n++)
        begin
            @(negedge link_clk_in);
            ok = rvalid_in;
        end
    endtask
endmodule

// file: verif/test_asr_status_regs.sv
`timescale 1ns/1ps
module test_asr_status_regs;
    logic        sys_clk_in = 1'b0, link_clk_in = 1'b0, rst_n_in = 1'b0;
    logic        address_strap_pin_in = 1'b1, iface_i2c_en_in = 1'b0, iface_spi_en_in = 1'b0;
    logic        fifo_en_in = 1'b0, clock_powerdown_flag_in = 1'b0, otp_powered_in = 1'b0;
    logic        sniff_active_in = 1'b0, sniff_detect_in = 1'b0, sample_valid_in = 1'b0;
    logic [13:0] x_sample_in = 14'h0, y_sample_in = 14'h0, z_sample_in = 14'h0;
    logic        link_start_in, link_stop_in, link_addr_load_in, link_read_in, link_write_in;
    logic [7:0]  link_addr_in, link_rdata_out, exp_q[$];
    logic [6:0]  i2c_base_addr_out;
    logic        continuous_wake_mode_out, sample_ready_out, link_rvalid_out, link_busy_out;
    logic [41:0] v, w, fq[$];
    logic [31:0] s = 32'h288a;
    int          num_errors = 0, n_compared = 0;
    bit          ok;

    initial
    begin
        forever #50 sys_clk_in = ~sys_clk_in;
    end
    initial
    begin
        #7;
        forever #15 link_clk_in = ~link_clk_in;
    end

    asr_status_regs #(.SAMPLE_W(14)) uut (.sys_clk_in, .rst_n_in, .address_strap_pin_in,
        .i2c_base_addr_out, .iface_i2c_en_in, .iface_spi_en_in, .fifo_en_in,
        .clock_powerdown_flag_in, .otp_powered_in, .sniff_active_in, .sniff_detect_in,
        .continuous_wake_mode_out, .sample_valid_in, .sample_ready_out, .x_sample_in,
        .y_sample_in, .z_sample_in, .link_clk_in, .link_start_in, .link_stop_in,
        .link_addr_load_in, .link_addr_in, .link_read_in, .link_write_in, .link_rdata_out,
        .link_rvalid_out, .link_busy_out);
    asr_host_model host (.link_clk_in, .busy_in(link_busy_out), .rvalid_in(link_rvalid_out),
        .start_out(link_start_in), .stop_out(link_stop_in), .load_out(link_addr_load_in),
        .addr_out(link_addr_in), .read_out(link_read_in), .write_out(link_write_in));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        for (int i = 0; i < 16; i++)
            x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
        return x;
    endfunction

    function automatic logic [47:0] ext(input logic [41:0] a, input bit f);
        logic [13:0] t;
        for (int i = 0; i < 3; i++)
        begin
            t = a[14*i+:14];
            ext[16*i+:16] = f ? {{4{t[13]}}, t[13:2]} : {{2{t[13]}}, t};
        end
    endfunction

    // An answer with nothing noted against it is forced to count as a mismatch.
    always @(negedge link_clk_in)
    begin
        if (link_rvalid_out === 1'b1)
        begin
            if (exp_q.size() == 0)
                check(16'h0001, 16'h0000);
            else
                check(link_rdata_out, exp_q.pop_front());
        end
    end

    task automatic rd(input logic [7:0] a, input bit ld, input logic [7:0] e);
        exp_q.push_back(e);
        host.xfer(a, ld, 1'b0, ok);
        check(ok, 1'b1);
        if (!ok)
            tally_and_finish();
    endtask

    task automatic burst(input logic [47:0] e, input int n);
        for (int i = 0; i < n; i++)
            rd(8'h02 + 8'(i), i == 0, e[8*i+:8]);
    endtask

    task automatic push(input logic [41:0] a, output bit tk);
        @(posedge sys_clk_in);
        sample_valid_in <= 1'b1;
        {z_sample_in, y_sample_in, x_sample_in} <= a;
        tk = 1'b0;
        for (int n = 0; n < 4 && !tk; n++)
        begin
            @(negedge sys_clk_in);
            tk = sample_ready_out;
        end
        @(posedge sys_clk_in);
        sample_valid_in <= 1'b0;
    endtask

    initial
    begin
        repeat (16) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        repeat (10) @(posedge sys_clk_in);
        check(i2c_base_addr_out, asr_pkg::ASR_I2C_BASE_HIGH);
        rd(asr_pkg::ASR_ADDR_SEL_OFF, 1'b1, 8'h08);
        for (int k = 0; k < 8; k++)
        begin
            s = lfsr(s);
            // The first pass raises watch and event together so the wake request is exercised.
            if (k == 0)
                s[3:2] = 2'h3;
            @(posedge sys_clk_in);
            {sniff_detect_in, sniff_active_in, otp_powered_in, clock_powerdown_flag_in} <= s[3:0];
            repeat (6) @(posedge sys_clk_in);
            rd(asr_pkg::ASR_COND_OFF, 1'b1, {s[3:1], 3'h0, s[0], 1'b0});
        end
        @(posedge sys_clk_in);
        {sniff_detect_in, sniff_active_in, otp_powered_in, clock_powerdown_flag_in} <= 4'h0;
        s = lfsr(s);
        push({s[9:0], s}, ok);
        repeat (4) @(posedge sys_clk_in);
        burst(48'h0, 2);
        @(posedge sys_clk_in);
        iface_i2c_en_in <= 1'b1;
        s = lfsr(s);
        v = {s[9:0], s};
        push(v, ok);
        repeat (3) @(posedge sys_clk_in);
        burst(ext(v, 1'b0), 6);
        s = lfsr(s);
        push({s[9:0], s}, ok);
        s = lfsr(s);
        w = {s[9:0], s};
        push(w, ok);
        repeat (3) @(posedge sys_clk_in);
        rd(asr_pkg::ASR_COND_OFF, 1'b1, 8'h01);
        rd(asr_pkg::ASR_COND_OFF, 1'b1, 8'h00);
        host.mark(1'b0);
        repeat (6) @(posedge sys_clk_in);
        s = lfsr(s);
        v = {s[9:0], s};
        push(v, ok);
        repeat (4) @(posedge sys_clk_in);
        host.xfer(asr_pkg::ASR_X_LO_OFF, 1'b1, 1'b1, ok);
        burst(ext(w, 1'b0), 6);
        host.mark(1'b1);
        repeat (6) @(posedge sys_clk_in);
        burst(ext(v, 1'b0), 6);
        @(posedge sys_clk_in);
        fifo_en_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        ok = 1'b1;
        for (int k = 0; k < 20 && ok; k++)
        begin
            s = lfsr(s);
            push({s[9:0], s}, ok);
            if (ok)
                fq.push_back({s[9:0], s});
        end
        check(16'(fq.size()), 16'(asr_pkg::ASR_FIFO_DEPTH));
        burst(ext(fq[0], 1'b1), 2);
        while (fq.size() > 0)
            burst(ext(fq.pop_front(), 1'b1), 6);
        check(sample_ready_out, 1'b1);
        repeat (4) @(posedge link_clk_in);
        tally_and_finish();
    end
endmodule

bind asr_status_regs asr_status_properties u_chk (.sys_clk_in, .rst_n_in, .i2c_base_addr_out,
    .fifo_en_in, .sniff_active_in, .sniff_detect_in, .continuous_wake_mode_out,
    .sample_ready_out, .link_clk_in, .link_read_in, .link_rdata_out, .link_rvalid_out,
    .link_busy_out);
